// ---- aarm_defines.vh ----
// constants for the access attribute region matcher
`ifndef AARM_DEFINES_VH
`define AARM_DEFINES_VH

// region register fields
`define AARM_BASE_HI      31
`define AARM_BASE_LO      24
`define AARM_MASK_HI      23
`define AARM_MASK_LO      16
`define AARM_EN_BIT       15
`define AARM_PRIV_ANY_BIT 14
`define AARM_PRIV_SUP_BIT 13
`define AARM_CI_BIT       6
`define AARM_BW_BIT       5
`define AARM_WP_BIT       2
`define AARM_ACR_WMASK    32'hFFFF_E064
`define AARM_ACR_RESET    32'h0000_0000
`define AARM_NUM_RGN      2

// register offsets on the software port
`define AARM_OFS_ACR0     8'h00
`define AARM_ACR_STRIDE   8'h04
`define AARM_OFS_STATUS   8'h08
`define AARM_OFS_CLEAR    8'h0C
`define AARM_OFS_IRQ_EN   8'h10
`define AARM_OFS_DBG_CFG  8'h14

// status, clear and enable layout
`define AARM_ST_WP        0
`define AARM_ST_WERR      1
`define AARM_ST_RERR      2
`define AARM_ST_W         3
`define AARM_ST_RESET     3'h0

// debug configuration bits
`define AARM_DBG_USER     0
`define AARM_DBG_IFETCH   1
`define AARM_DBG_RESET    2'h0

// attributes used when no region matches
`define AARM_DEF_CI       1'b0
`define AARM_DEF_BW       1'b0
`define AARM_DEF_WP       1'b0

// sequencer states
`define AARM_S_IDLE       2'h0
`define AARM_S_SYS        2'h1
`define AARM_S_DRAIN      2'h2

`define AARM_ZERO32       32'h0000_0000
`define AARM_ZERO8        8'h00

`endif

// ---- aarm_region_match.v ----
// region attribute matcher with local bus sequencer and registers
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "aarm_defines.vh"

module aarm_region_match (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_arst_n,
   // register port
   input  wire [7:0]  i_reg_addr,
   input  wire [31:0] i_reg_wdata,
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   output wire [31:0] o_reg_rdata,
   // core side of local bus
   input  wire        i_cpu_req,
   input  wire [31:0] i_cpu_addr,
   input  wire [31:0] i_cpu_wdata,
   input  wire        i_cpu_write,
   input  wire        i_cpu_super,
   input  wire        i_cpu_ifetch,
   // debug unit side of local bus
   input  wire        i_dbg_req,
   input  wire [31:0] i_dbg_addr,
   input  wire [31:0] i_dbg_wdata,
   input  wire        i_dbg_write,
   // local bus answer
   output wire        o_lb_ready,
   output wire        o_lb_done,
   output wire        o_lb_err,
   output wire        o_lb_dbg,
   output wire [31:0] o_lb_rdata,
   output wire        o_lb_hit,
   output wire        o_lb_cache_inhibit,
   output wire        o_lb_buffered,
   output wire        o_lb_wprot,
   output wire        o_wr_err,
   // system bus
   output wire        o_sb_req,
   output wire [31:0] o_sb_addr,
   output wire [31:0] o_sb_wdata,
   output wire        o_sb_write,
   output wire        o_sb_super,
   output wire        o_sb_ifetch,
   input  wire        i_sb_done,
   input  wire        i_sb_err,
   input  wire [31:0] i_sb_rdata,
   // interrupt
   output wire        o_irq
);

   // software-visible state
   // two regions, fixed; region 0 sits at the lowest offset
   reg  [31:0] acr_r [0:`AARM_NUM_RGN-1];
   reg  [2:0]  status_r;
   reg  [2:0]  irq_en_r;
   reg  [1:0]  dbg_cfg_r;
   reg  [31:0] rdata_r;
   reg         irq_r;

   // sequencer state
   // the attribute and system bus registers hold their last values
   // between transfers; only the strobes and sb_req_r fall back to zero
   reg  [1:0]  state_r;
   reg         ready_r;
   reg         done_r;
   reg         err_r;
   reg         dbg_r;
   reg  [31:0] lb_rdata_r;
   reg         hit_r;
   reg         ci_r;
   reg         bw_r;
   reg         wp_r;
   reg         wr_err_r;
   reg         sb_req_r;
   reg  [31:0] sb_addr_r;
   reg  [31:0] sb_wdata_r;
   reg         sb_write_r;
   reg         sb_super_r;
   reg         sb_ifetch_r;
   reg         cur_write_r;

   // event pulses into the sticky status
   // bit order matches status, clear and enable alike
   reg  [2:0]  ev_set;

   // request selection: the core wins a tie, the debug unit retries
   // a debug request that loses the tie gets no answer at all, so the
   // debug unit must present it again once ready comes back; from the
   // take onward both sources run down the very same path
   wire        take    = ready_r & (i_cpu_req | i_dbg_req);
   wire        use_cpu = i_cpu_req;
   wire [31:0] req_addr  = use_cpu ? i_cpu_addr  : i_dbg_addr;
   wire [31:0] req_wdata = use_cpu ? i_cpu_wdata : i_dbg_wdata;
   wire        req_write = use_cpu ? i_cpu_write : i_dbg_write;
   // debug references: supervisor data unless configured
   wire        req_super = use_cpu ? i_cpu_super
                                   : ~dbg_cfg_r[`AARM_DBG_USER];
   wire        req_ifetch = use_cpu ? i_cpu_ifetch
                                    : dbg_cfg_r[`AARM_DBG_IFETCH];
   wire [7:0]  req_top = req_addr[`AARM_BASE_HI:`AARM_BASE_LO];

   // per-region match and register storage
   // matching is pure logic on the presented address, so a region's
   // verdict settles inside the take cycle and is latched with it; no
   // extra cycle is spent on the compare
   wire [`AARM_NUM_RGN-1:0] hit;
   genvar g;
   generate
      for (g = 0; g < `AARM_NUM_RGN; g = g + 1) begin : gen_rgn
         localparam [31:0] OFS_W = `AARM_OFS_ACR0 + g * `AARM_ACR_STRIDE;
         localparam [7:0]  OFS   = OFS_W[7:0];
         wire [7:0] base = acr_r[g][`AARM_BASE_HI:`AARM_BASE_LO];
         wire [7:0] mask = acr_r[g][`AARM_MASK_HI:`AARM_MASK_LO];
         // masked bits never take part in the compare
         wire addr_ok = (((base ^ req_top) & ~mask) == `AARM_ZERO8);
         // 1x matches any mode, else low bit picks supervisor
         wire priv_ok = acr_r[g][`AARM_PRIV_ANY_BIT] |
                        (acr_r[g][`AARM_PRIV_SUP_BIT] == req_super);
         assign hit[g] = acr_r[g][`AARM_EN_BIT] & addr_ok & priv_ok;

         // reserved bits are forced to zero on write
         // a rewrite during a transfer only steers the next take; the
         // attributes already latched for the running one stay put
         always @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               acr_r[g] <= `AARM_ACR_RESET;
            end else if (i_reg_wr && i_reg_addr == OFS) begin
               acr_r[g] <= i_reg_wdata & `AARM_ACR_WMASK;
            end
         end
      end
   endgenerate

   // attribute selection; lowest numbered region has priority
   // overlap is settled by region number alone, never by how many
   // mask bits are set; software that overlaps regions must order them
   reg         sel_hit;
   reg         sel_ci;
   reg         sel_bw;
   reg         sel_wp;
   always @* begin
      sel_hit = 1'b1;
      if (hit[0]) begin
         sel_ci = acr_r[0][`AARM_CI_BIT];
         sel_bw = acr_r[0][`AARM_BW_BIT];
         sel_wp = acr_r[0][`AARM_WP_BIT];
      end else if (hit[1]) begin
         sel_ci = acr_r[1][`AARM_CI_BIT];
         sel_bw = acr_r[1][`AARM_BW_BIT];
         sel_wp = acr_r[1][`AARM_WP_BIT];
      end else begin
         sel_hit = 1'b0;
         sel_ci  = `AARM_DEF_CI;
         sel_bw  = `AARM_DEF_BW;
         sel_wp  = `AARM_DEF_WP;
      end
   end

   // local bus sequencer; core and debug share one path
   // three ways through: a protected write ends at once with an error,
   // a buffered write ends at once and drains in the background, and a
   // read or unbuffered write waits for the system bus answer; ready
   // stays low throughout, so at most one system cycle is outstanding
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r     <= `AARM_S_IDLE;
         ready_r     <= 1'b0;
         done_r      <= 1'b0;
         err_r       <= 1'b0;
         dbg_r       <= 1'b0;
         lb_rdata_r  <= `AARM_ZERO32;
         hit_r       <= 1'b0;
         ci_r        <= `AARM_DEF_CI;
         bw_r        <= `AARM_DEF_BW;
         wp_r        <= `AARM_DEF_WP;
         wr_err_r    <= 1'b0;
         sb_req_r    <= 1'b0;
         sb_addr_r   <= `AARM_ZERO32;
         sb_wdata_r  <= `AARM_ZERO32;
         sb_write_r  <= 1'b0;
         sb_super_r  <= 1'b0;
         sb_ifetch_r <= 1'b0;
         cur_write_r <= 1'b0;
      end else begin
         done_r   <= 1'b0;
         err_r    <= 1'b0;
         wr_err_r <= 1'b0;
         case (state_r)
            `AARM_S_IDLE: begin
               ready_r <= 1'b1;
               if (take) begin
                  dbg_r       <= ~use_cpu;
                  hit_r       <= sel_hit;
                  ci_r        <= sel_ci;
                  bw_r        <= sel_bw;
                  wp_r        <= sel_wp;
                  cur_write_r <= req_write;
                  if (req_write && sel_wp) begin
                     // protected write never reaches the system bus
                     // and leaves the sticky protect bit behind
                     done_r  <= 1'b1;
                     err_r   <= 1'b1;
                     ready_r <= 1'b0;
                  end else begin
                     ready_r     <= 1'b0;
                     sb_req_r    <= 1'b1;
                     sb_addr_r   <= req_addr;
                     sb_wdata_r  <= req_wdata;
                     sb_write_r  <= req_write;
                     sb_super_r  <= req_super;
                     sb_ifetch_r <= req_ifetch;
                     if (req_write && sel_bw) begin
                        // local cycle ends now, bus controller holds it
                        done_r  <= 1'b1;
                        state_r <= `AARM_S_DRAIN;
                     end else begin
                        state_r <= `AARM_S_SYS;
                     end
                  end
               end
            end
            `AARM_S_SYS: begin
               // unbuffered write or read waits for the system bus
               // no timeout here: a silent system bus stalls the local
               // bus until reset, so the far side must always answer
               if (i_sb_done) begin
                  sb_req_r <= 1'b0;
                  done_r   <= 1'b1;
                  // read errors are precise, write errors are not
                  err_r    <= i_sb_err & ~cur_write_r;
                  wr_err_r <= i_sb_err & cur_write_r;
                  if (!cur_write_r) begin
                     lb_rdata_r <= i_sb_rdata;
                  end
                  state_r  <= `AARM_S_IDLE;
               end
            end
            `AARM_S_DRAIN: begin
               // error shows up well after the writer moved on
               // ready stays low until the drain ends, trading a little
               // throughput for a single outstanding system cycle
               if (i_sb_done) begin
                  sb_req_r <= 1'b0;
                  wr_err_r <= i_sb_err;
                  state_r  <= `AARM_S_IDLE;
               end
            end
            default: begin
               state_r  <= `AARM_S_IDLE;
               sb_req_r <= 1'b0;
               ready_r  <= 1'b0;
            end
         endcase
      end
   end

   // events feeding the sticky status bits
   // these are one-cycle pulses taken from the same terms that steer
   // the sequencer, so status and bus answer can never disagree
   always @* begin
      ev_set = `AARM_ST_RESET;
      ev_set[`AARM_ST_WP] = (state_r == `AARM_S_IDLE) & take &
                            req_write & sel_wp;
      ev_set[`AARM_ST_WERR] = (state_r != `AARM_S_IDLE) & i_sb_done &
                              i_sb_err & sb_write_r;
      ev_set[`AARM_ST_RERR] = (state_r == `AARM_S_SYS) & i_sb_done &
                              i_sb_err & ~sb_write_r;
   end

   // status, enables and debug config; a set beats a same-cycle clear
   // the clear register has no storage: a write only masks the status
   // for that one edge, and reading its offset returns zero
   wire clr_hit = i_reg_wr & (i_reg_addr == `AARM_OFS_CLEAR);
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         status_r  <= `AARM_ST_RESET;
         irq_en_r  <= `AARM_ST_RESET;
         dbg_cfg_r <= `AARM_DBG_RESET;
         irq_r     <= 1'b0;
      end else begin
         status_r <= (status_r &
                      ~(clr_hit ? i_reg_wdata[`AARM_ST_W-1:0]
                                : `AARM_ST_RESET)) | ev_set;
         if (i_reg_wr && i_reg_addr == `AARM_OFS_IRQ_EN) begin
            irq_en_r <= i_reg_wdata[`AARM_ST_W-1:0];
         end
         if (i_reg_wr && i_reg_addr == `AARM_OFS_DBG_CFG) begin
            dbg_cfg_r <= i_reg_wdata[`AARM_DBG_IFETCH:`AARM_DBG_USER];
         end
         // one cycle behind the status so the pin comes from a flop
         // an enable written high with status already set raises it too
         irq_r <= |(status_r & irq_en_r);
      end
   end

   // read data valid the cycle after the strobe, zero otherwise
   // returning zero outside the read cycle lets several slaves share
   // one read bus through a plain or of their data words
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= `AARM_ZERO32;
      end else begin
         rdata_r <= `AARM_ZERO32;
         if (i_reg_rd) begin
            case (i_reg_addr)
               `AARM_OFS_ACR0:
                  rdata_r <= acr_r[0];
               `AARM_OFS_ACR0 + `AARM_ACR_STRIDE:
                  rdata_r <= acr_r[1];
               `AARM_OFS_STATUS:
                  rdata_r <= {29'h0000_0000, status_r};
               `AARM_OFS_IRQ_EN:
                  rdata_r <= {29'h0000_0000, irq_en_r};
               `AARM_OFS_DBG_CFG:
                  rdata_r <= {30'h0000_0000, dbg_cfg_r};
               default:
                  rdata_r <= `AARM_ZERO32;
            endcase
         end
      end
   end

   // outputs, all from flops
   // no logic after these flops, so every pin leaves clean
   assign o_reg_rdata        = rdata_r;
   assign o_lb_ready         = ready_r;
   assign o_lb_done          = done_r;
   assign o_lb_err           = err_r;
   assign o_lb_dbg           = dbg_r;
   assign o_lb_rdata         = lb_rdata_r;
   assign o_lb_hit           = hit_r;
   assign o_lb_cache_inhibit = ci_r;
   assign o_lb_buffered      = bw_r;
   assign o_lb_wprot         = wp_r;
   assign o_wr_err           = wr_err_r;
   assign o_sb_req           = sb_req_r;
   assign o_sb_addr          = sb_addr_r;
   assign o_sb_wdata         = sb_wdata_r;
   assign o_sb_write         = sb_write_r;
   assign o_sb_super         = sb_super_r;
   assign o_sb_ifetch        = sb_ifetch_r;
   assign o_irq              = irq_r;

endmodule // aarm_region_match

// ---- aarm_region_match_checker.sv ----
// assertions for the region attribute matcher
`timescale 1ns/1ps
module aarm_region_match_checker (
   // clock and reset
   input wire        i_clk,
   input wire        i_arst_n,
   // inputs watched
   input wire        i_cpu_req,
   input wire        i_cpu_write,
   input wire        i_sb_done,
   input wire        i_sb_err,
   // outputs watched
   input wire        o_lb_ready,
   input wire        o_lb_done,
   input wire        o_lb_err,
   input wire        o_lb_hit,
   input wire        o_lb_cache_inhibit,
   input wire        o_lb_buffered,
   input wire        o_lb_wprot,
   input wire        o_wr_err,
   input wire        o_sb_req,
   input wire        o_sb_write,
   input wire [31:0] o_sb_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // core write taken; system bus write failing
   wire cw = o_lb_ready && i_cpu_req && i_cpu_write;
   wire we = o_sb_req && i_sb_done && i_sb_err && o_sb_write;
   a_wp_write_err: assert property (cw ##1 o_lb_wprot |->
      o_lb_done && o_lb_err && !o_sb_req) else $error("protected write");
   a_err_paired: assert property (o_lb_err |-> o_lb_done)
      else $error("error without done");
   a_buf_quick: assert property (cw ##1 o_lb_buffered && !o_lb_wprot
      |-> o_lb_done && o_sb_req) else $error("buffered write slow");
   a_unbuf_hold: assert property (cw ##1 !o_lb_buffered && !o_lb_wprot
      |-> !o_lb_done && o_sb_req) else $error("unbuffered write early");
   a_end_after_sb: assert property (o_sb_req && i_sb_done &&
      !(o_sb_write && o_lb_buffered) |=> o_lb_done) else $error("no end");
   a_sb_hold: assert property (o_sb_req && !i_sb_done |=>
      o_sb_req && $stable(o_sb_addr)) else $error("system cycle dropped");
   a_default_attr: assert property (!o_lb_hit |-> !o_lb_cache_inhibit
      && !o_lb_buffered && !o_lb_wprot) else $error("bad default");
   a_wr_err_src: assert property (o_wr_err |-> $past(we))
      else $error("stray write error");
   // main scenarios reached
   c_prot: cover property (cw ##1 o_lb_wprot);
   c_buf: cover property (cw ##1 o_lb_buffered);
   c_werr: cover property (o_wr_err);
endmodule // aarm_region_match_checker

bind aarm_region_match aarm_region_match_checker aarm_region_match_checker_i (.*);

// ---- aarm_region_match_tb_top.sv ----
// testbench for the region attribute matcher
`timescale 1ns/1ps
module aarm_region_match_tb_top;
   reg         i_clk = 1'b0;
   reg         i_arst_n = 1'b0;
   reg  [7:0]  ra = 8'h00;
   reg  [31:0] rw = 32'h0000_0000;
   reg  [31:0] ad = 32'h0000_0000;
   reg         wr = 1'b0, rd = 1'b0, creq = 1'b0, dreq = 1'b0;
   reg         cwr = 1'b0, csup = 1'b0, serr = 1'b0;
   reg  [3:0]  sdly = 4'h2;
   wire [31:0] rdat, lrd, sad, srd, swd;
   wire        swr, ssup, sif;
   wire        rdy, dn, er, dbg, hit, ci, bw, wp, wer, sreq, sdn, ser, irq;
   integer     errors = 0, n_compared = 0, n, i;
   reg  [31:0] v, wdv;
   reg  [2:0]  sbf;

   // 10 MHz clock
   always #50 i_clk = ~i_clk;

   aarm_region_match aarm_region_match_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_wr(wr), .i_reg_rd(rd),
      .o_reg_rdata(rdat), .i_cpu_req(creq), .i_cpu_addr(ad),
      .i_cpu_wdata(ad), .i_cpu_write(cwr), .i_cpu_super(csup),
      .i_cpu_ifetch(1'b0), .i_dbg_req(dreq), .i_dbg_addr(ad),
      .i_dbg_wdata(ad), .i_dbg_write(cwr), .o_lb_ready(rdy), .o_lb_done(dn),
      .o_lb_err(er), .o_lb_dbg(dbg), .o_lb_rdata(lrd), .o_lb_hit(hit),
      .o_lb_cache_inhibit(ci), .o_lb_buffered(bw), .o_lb_wprot(wp),
      .o_wr_err(wer), .o_sb_req(sreq), .o_sb_addr(sad), .o_sb_wdata(swd),
      .o_sb_write(swr), .o_sb_super(ssup), .o_sb_ifetch(sif),
      .i_sb_done(sdn),
      .i_sb_err(ser), .i_sb_rdata(srd), .o_irq(irq));

   aarm_sb_model aarm_sb_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_req(sreq), .i_addr(sad), .i_err_en(serr), .i_delay(sdly),
      .o_done(sdn), .o_err(ser), .o_rdata(srd));

   // region word from fields; reserved bits stay zero
   function [31:0] mk(input [7:0] b, input [7:0] m, input [1:0] p,
                      input c, input f, input w);
      mk = {b, m, 1'b1, p, 6'h00, c, f, 2'b00, w, 2'b00};
   endfunction

   task chk(input ok, input [8*20:1] m);
      begin
         n_compared = n_compared + 1;
         if (ok !== 1'b1) begin
            errors = errors + 1;
            $display("[ERR] %0t %0s", $time, m);
         end
      end
   endtask

   task rwr(input [7:0] a, input [31:0] d);
      begin
         @(posedge i_clk); ra <= a; rw <= d; wr <= 1'b1;
         @(posedge i_clk); wr <= 1'b0;
      end
   endtask

   // read data lands only in the cycle after the strobe
   task rrd(input [7:0] a);
      begin
         @(posedge i_clk); ra <= a; rd <= 1'b1;
         @(posedge i_clk); rd <= 1'b0;
         @(negedge i_clk); v = rdat;
      end
   endtask

   // one local transfer; n counts cycles from the take to done
   task op(input d, input [31:0] a, input w, input s);
      begin
         n = 0;
         @(negedge i_clk);
         while (rdy !== 1'b1 && n < 50) begin n = n + 1; @(negedge i_clk); end
         chk(n < 50, "ready timeout");
         @(posedge i_clk); creq <= !d; dreq <= d; ad <= a; cwr <= w; csup <= s;
         @(posedge i_clk); creq <= 1'b0; dreq <= 1'b0;
         n = 0;
         @(negedge i_clk);
         sbf = {swr, ssup, sif};
         wdv = swd;
         while (dn !== 1'b1 && n < 50) begin n = n + 1; @(negedge i_clk); end
         chk(n < 50, "done timeout");
      end
   endtask

   task t_reset;
      begin
         rrd(8'h00); chk(v === 32'h0000_0000, "region0 reset");
         op(0, 32'h0000_0000, 0, 1); chk(hit === 1'b0, "hit at reset");
         rwr(8'h04, 32'hFFFF_FFFF); rrd(8'h04);
         chk(v === 32'hFFFF_E064, "region1 fields");
         rwr(8'h04, 32'h0000_0000); rrd(8'h40); chk(v === 32'h0, "unmapped");
         $display("t_reset done");
      end
   endtask

   task t_match;
      begin
         rwr(8'h00, mk(8'h12, 8'h01, 2'b10, 1, 0, 0));
         op(0, 32'h1300_0000, 0, 0); chk(hit === 1'b1, "masked hit");
         chk(ci === 1'b1 && lrd === 32'hECFF_FFFF, "cache off");
         op(0, 32'h1600_0000, 0, 0); chk(hit === 1'b0, "base miss");
         chk(ci === 1'b0 && bw === 1'b0 && wp === 1'b0, "default");
         rwr(8'h00, mk(8'h16, 8'h00, 2'b10, 0, 0, 0));
         op(0, 32'h1600_0000, 0, 0); chk(hit && ci === 1'b0, "cache on");
         $display("t_match done");
      end
   endtask

   task t_priv;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            rwr(8'h00, mk(8'h20, 8'h00, i[2:1], 0, 0, 0));
            op(0, 32'h2000_0000, 0, i[0]);
            chk(hit === (i[2] | (i[1] == i[0])), "privilege");
         end
         $display("t_priv done");
      end
   endtask

   task t_debug;
      begin
         rwr(8'h00, mk(8'h30, 8'h00, 2'b01, 0, 0, 0));
         op(1, 32'h3000_0000, 0, 0); chk(hit && dbg === 1'b1, "debug");
         chk(sbf === 3'b010, "debug super data");
         rwr(8'h14, 32'h0000_0003);
         op(1, 32'h3000_0000, 0, 0); chk(hit === 1'b0, "debug user");
         chk(sbf === 3'b001, "debug user ifetch");
         rwr(8'h14, 32'h0000_0000);
         $display("t_debug done");
      end
   endtask

   task t_write;
      begin
         sdly <= 4'h4; serr <= 1'b1;
         rwr(8'h00, mk(8'h40, 8'h00, 2'b10, 0, 1, 0));
         op(0, 32'h4000_0000, 1, 1); chk(n === 0 && sreq === 1'b1, "buffered");
         chk(sbf === 3'b110 && wdv === 32'h4000_0000, "buffered fields");
         n = 0;
         while (wer !== 1'b1 && n < 30) begin n = n + 1; @(negedge i_clk); end
         chk(wer === 1'b1, "late write error");
         serr <= 1'b0;
         op(0, 32'h4100_0000, 1, 1); chk(n > 4 && er === 1'b0, "unbuffered");
         rrd(8'h08); chk(v[1] === 1'b1, "write error status");
         rwr(8'h0C, 32'h0000_0007);
         $display("t_write done");
      end
   endtask

   task t_wprot;
      begin
         rwr(8'h00, mk(8'h50, 8'h00, 2'b10, 0, 0, 1)); rwr(8'h10, 32'h1);
         op(0, 32'h5000_0000, 1, 1); chk(er && n === 0 && !sreq, "protect");
         repeat (2) @(negedge i_clk); chk(irq === 1'b1, "irq raised");
         rwr(8'h10, 32'h0); repeat (2) @(negedge i_clk);
         chk(irq === 1'b0, "irq masked");
         rrd(8'h08); chk(v === 32'h0000_0001, "status");
         rwr(8'h10, 32'h1); rwr(8'h0C, 32'h1); repeat (2) @(negedge i_clk);
         chk(irq === 1'b0, "irq cleared");
         op(0, 32'h5000_0000, 0, 1); chk(wp && er === 1'b0, "read ok");
         $display("t_wprot done");
      end
   endtask

   task print_verdict;
      begin
         $display("compared %0d mismatches %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask

   // reset for 20 cycles, then the scenarios
   initial begin
      repeat (20) @(posedge i_clk);
      i_arst_n <= 1'b1;
      t_reset; t_match; t_priv; t_debug; t_write; t_wprot;
      print_verdict;
   end

   // watchdog far beyond the few hundred cycles needed
   initial begin
      #2_000_000;
      errors = errors + 1;
      print_verdict;
   end
endmodule // aarm_region_match_tb_top

// ---- aarm_sb_model.sv ----
// system bus responder with settable wait and error
`timescale 1ns/1ps
module aarm_sb_model (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_arst_n,
   // request from the matcher
   input  wire        i_req,
   input  wire [31:0] i_addr,
   // behaviour set by the bench
   input  wire        i_err_en,
   input  wire [3:0]  i_delay,
   // answer
   output reg         o_done,
   output reg         o_err,
   output reg  [31:0] o_rdata
);
   reg [3:0] cnt_r;
   reg       fin_r;
   reg [3:0] tk_r;
   // one answer per request; data wanders outside the answer cycle
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= 4'h0;
         fin_r <= 1'b0;
         tk_r <= 4'h0;
         o_done <= 1'b0;
         o_err <= 1'b0;
         o_rdata <= 32'h0000_0000;
      end else begin
         tk_r <= tk_r + 4'h1;
         o_done <= 1'b0;
         o_err <= 1'b0;
         o_rdata <= {8{tk_r}};
         if (!i_req) begin
            cnt_r <= 4'h0;
            fin_r <= 1'b0;
         end else if (!fin_r) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == i_delay) begin
               o_done <= 1'b1;
               o_err <= i_err_en;
               o_rdata <= ~i_addr;
               fin_r <= 1'b1;
            end
         end
      end
   end
endmodule // aarm_sb_model
